// ---- rtl/ddrb_pkg.sv ----
// constants for the double-data-rate burst read/write engine
package ddrb_pkg;

    // register byte offsets
    localparam logic [7:0] DDRB_CTRL_OFS = 8'h00;
    localparam logic [7:0] DDRB_LAT_OFS = 8'h04;
    localparam logic [7:0] DDRB_STAT_OFS = 8'h08;

    // control register fields
    localparam int DDRB_CTRL_BLF_LSB = 0;
    localparam int DDRB_CTRL_TERM_BIT = 2;

    // latency register fields, each five bits wide
    localparam int DDRB_LAT_FW = 5;
    localparam int DDRB_LAT_AL_LSB = 0;
    localparam int DDRB_LAT_CL_LSB = 8;
    localparam int DDRB_LAT_CWL_LSB = 16;

    // status register fields, each an eight-bit event count
    localparam int DDRB_STAT_RD_LSB = 0;
    localparam int DDRB_STAT_WR_LSB = 8;
    localparam int DDRB_STAT_VIO_LSB = 16;

    // burst-length field codes
    localparam logic [1:0] DDRB_BLF_FIXED8 = 2'h0;
    localparam logic [1:0] DDRB_BLF_OTF = 2'h1;
    localparam logic [1:0] DDRB_BLF_CHOP4 = 2'h2;

    // values after reset
    localparam logic [1:0] DDRB_BLF_RST = 2'h1;
    localparam logic DDRB_TERM_RST = 1'h0;
    localparam logic [4:0] DDRB_AL_RST = 5'h00;
    localparam logic [4:0] DDRB_CL_RST = 5'h06;
    localparam logic [4:0] DDRB_CWL_RST = 5'h05;

    // beats per burst
    localparam logic [3:0] DDRB_BEATS_BL8 = 4'h8;
    localparam logic [3:0] DDRB_BEATS_BC4 = 4'h4;

    // latency pipeline length, covers AL + CL up to 62 clocks
    localparam int DDRB_PIPE_DEPTH = 64;
    localparam logic [5:0] DDRB_LAT_MIN = 6'h02;

endpackage

// ---- rtl/ddrb_burst.sv ----
// burst read/write engine of a ddr dram with apb configuration
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ddrb_burst
    import ddrb_pkg::*;
#(
    parameter int DQ_W = 8,
    parameter int COL_W = 6,
    parameter int BANK_W = 3
)
(
    // core clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link clock
    input wire logic link_clk,
    // command from the memory controller
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [BANK_W-1:0] cmd_bank,
    input wire logic [COL_W-1:0] cmd_col,
    input wire logic cmd_a12,
    // write data
    input wire logic [DQ_W-1:0] wr_data,
    input wire logic [DQ_W/8-1:0] write_byte_mask,
    input wire logic wr_strobe_fault,
    output logic wr_beat,
    output logic termination_strobe,
    // read data
    output logic [DQ_W-1:0] rd_data,
    output logic rd_valid
);

    localparam int LANES = DQ_W / 8;
    localparam int AW = BANK_W + COL_W;
    localparam int DEPTH = 1 << AW;
    localparam int PW = 3 + BANK_W + COL_W;

    // refuse shapes the lane and burst logic cannot serve
    if (DQ_W < 8 || DQ_W % 8 != 0 || COL_W < 3 || BANK_W < 1)
    begin : g_bad_param
        $error("ddrb_burst: unsupported DQ_W, COL_W or BANK_W");
    end

    // core-domain configuration and status
    logic [1:0] blf_r;
    logic term_en_r;
    logic [4:0] al_r;
    logic [4:0] cl_r;
    logic [4:0] cwl_r;
    logic [7:0] rd_cnt_r;
    logic [7:0] wr_cnt_r;
    logic [7:0] vio_cnt_r;
    logic [31:0] prdata_r;
    logic hit_ctrl;
    logic hit_lat;
    logic hit_stat;
    logic [2:0] ev_s1_r;
    logic [2:0] ev_s2_r;
    logic [2:0] ev_s3_r;

    // link-domain signals
    logic [1:0] lrst_r;
    logic lrst_n;
    logic [18:0] cfg_s1_r;
    logic [18:0] cfg_s2_r;
    logic [PW-1:0] pipe_r [DDRB_PIPE_DEPTH];
    logic [5:0] rl;
    logic [5:0] wl;
    logic [5:0] rl_tap;
    logic [5:0] wl_tap;
    logic [PW-1:0] r_ent;
    logic [PW-1:0] w_ent;
    logic cmd_bl8;
    logic [3:0] r_left_r;
    logic [3:0] r_beat_r;
    logic r_bl8_r;
    logic [AW-1:0] r_base_r;
    logic [3:0] w_left_r;
    logic [3:0] w_beat_r;
    logic w_bl8_r;
    logic [AW-1:0] w_base_r;
    logic w_fault_r;
    logic [AW-1:0] r_idx;
    logic [AW-1:0] w_idx;
    logic [DQ_W-1:0] r_word;
    logic [DQ_W-1:0] rd_data_r;
    logic rd_valid_r;
    logic [2:0] ev_tgl_r;

    // synced configuration fields
    logic [1:0] s_blf;
    logic s_term;
    logic [4:0] s_al;
    logic [4:0] s_cl;
    logic [4:0] s_cwl;

    // column order inside a burst wraps within the chop or the eight
    function automatic logic [AW-1:0] beat_idx(input logic [AW-1:0] base,
        input logic [3:0] beat, input logic bl8);
        logic [AW-1:0] idx;
        idx = base;
        if (bl8)
            idx[2:0] = base[2:0] + beat[2:0];
        else
            idx[1:0] = base[1:0] + beat[1:0];
        return idx;
    endfunction

    // apb decode; zero wait states, unmapped offsets answer with an error
    assign hit_ctrl = (paddr == DDRB_CTRL_OFS);
    assign hit_lat = (paddr == DDRB_LAT_OFS);
    assign hit_stat = (paddr == DDRB_STAT_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_ctrl || hit_lat || hit_stat);
    assign prdata = prdata_r;

    // configuration registers, written in the access phase only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            blf_r <= DDRB_BLF_RST;
            term_en_r <= DDRB_TERM_RST;
            al_r <= DDRB_AL_RST;
            cl_r <= DDRB_CL_RST;
            cwl_r <= DDRB_CWL_RST;
        end
        else if (psel && penable && pwrite)
        begin
            if (hit_ctrl)
            begin
                blf_r <= pwdata[DDRB_CTRL_BLF_LSB +: 2];
                term_en_r <= pwdata[DDRB_CTRL_TERM_BIT];
            end
            if (hit_lat)
            begin
                al_r <= pwdata[DDRB_LAT_AL_LSB +: DDRB_LAT_FW];
                cl_r <= pwdata[DDRB_LAT_CL_LSB +: DDRB_LAT_FW];
                cwl_r <= pwdata[DDRB_LAT_CWL_LSB +: DDRB_LAT_FW];
            end
        end
    end

    // read data captured in the setup phase so it is a flop in access
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            prdata_r <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            prdata_r <= 32'h0000_0000;
            if (hit_ctrl)
            begin
                prdata_r[DDRB_CTRL_BLF_LSB +: 2] <= blf_r;
                prdata_r[DDRB_CTRL_TERM_BIT] <= term_en_r;
            end
            if (hit_lat)
            begin
                prdata_r[DDRB_LAT_AL_LSB +: DDRB_LAT_FW] <= al_r;
                prdata_r[DDRB_LAT_CL_LSB +: DDRB_LAT_FW] <= cl_r;
                prdata_r[DDRB_LAT_CWL_LSB +: DDRB_LAT_FW] <= cwl_r;
            end
            if (hit_stat)
            begin
                prdata_r[DDRB_STAT_RD_LSB +: 8] <= rd_cnt_r;
                prdata_r[DDRB_STAT_WR_LSB +: 8] <= wr_cnt_r;
                prdata_r[DDRB_STAT_VIO_LSB +: 8] <= vio_cnt_r;
            end
        end
    end

    // burst events arrive as toggles from the link side
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ev_s1_r <= 3'h0;
            ev_s2_r <= 3'h0;
            ev_s3_r <= 3'h0;
        end
        else
        begin
            ev_s1_r <= ev_tgl_r;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
        end
    end

    // event counters wrap; software takes differences
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_cnt_r <= 8'h00;
            wr_cnt_r <= 8'h00;
            vio_cnt_r <= 8'h00;
        end
        else
        begin
            rd_cnt_r <= rd_cnt_r + {7'h00, ev_s2_r[0] ^ ev_s3_r[0]};
            wr_cnt_r <= wr_cnt_r + {7'h00, ev_s2_r[1] ^ ev_s3_r[1]};
            vio_cnt_r <= vio_cnt_r + {7'h00, ev_s2_r[2] ^ ev_s3_r[2]};
        end
    end

    // link reset: asserts at once, releases on the link clock
    always_ff @(posedge link_clk or negedge nrst)
    begin
        if (!nrst)
            lrst_r <= 2'h0;
        else
            lrst_r <= {lrst_r[0], 1'b1};
    end
    assign lrst_n = lrst_r[1];

    // config is quasi-static; change it only while the link is idle
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            cfg_s1_r <= {DDRB_BLF_RST, DDRB_TERM_RST, DDRB_AL_RST,
                DDRB_CL_RST, DDRB_CWL_RST, 1'b0};
            cfg_s2_r <= {DDRB_BLF_RST, DDRB_TERM_RST, DDRB_AL_RST,
                DDRB_CL_RST, DDRB_CWL_RST, 1'b0};
        end
        else
        begin
            cfg_s1_r <= {blf_r, term_en_r, al_r, cl_r, cwl_r, 1'b0};
            cfg_s2_r <= cfg_s1_r;
        end
    end
    assign s_blf = cfg_s2_r[18:17];
    assign s_term = cfg_s2_r[16];
    assign s_al = cfg_s2_r[15:11];
    assign s_cl = cfg_s2_r[10:6];
    assign s_cwl = cfg_s2_r[5:1];

    // burst length from the mode field and bit twelve
    always_comb
    begin
        unique case (s_blf)
            DDRB_BLF_FIXED8: cmd_bl8 = 1'b1;
            DDRB_BLF_OTF: cmd_bl8 = cmd_a12;
            DDRB_BLF_CHOP4: cmd_bl8 = 1'b0;
            default: cmd_bl8 = 1'b0;
        endcase
    end

    // latencies; below two clocks they are held at two
    assign rl = {1'b0, s_al} + {1'b0, s_cl};
    assign wl = {1'b0, s_al} + {1'b0, s_cwl};
    assign rl_tap = (rl < DDRB_LAT_MIN) ? 6'h00 : rl - DDRB_LAT_MIN;
    assign wl_tap = (wl < DDRB_LAT_MIN) ? 6'h00 : wl - DDRB_LAT_MIN;
    assign r_ent = pipe_r[rl_tap];
    assign w_ent = pipe_r[wl_tap];

    // command delay line: {valid, write, bl8, bank, column}
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            for (int i = 0; i < DDRB_PIPE_DEPTH; i++)
                pipe_r[i] <= '0;
        end
        else
        begin
            // bit twelve steers length only, never the column
            pipe_r[0] <= {cmd_valid, cmd_write, cmd_bl8, cmd_bank,
                cmd_col};
            for (int i = 1; i < DDRB_PIPE_DEPTH; i++)
                pipe_r[i] <= pipe_r[i-1];
        end
    end

    assign r_idx = beat_idx(r_base_r, r_beat_r, r_bl8_r);
    assign w_idx = beat_idx(w_base_r, w_beat_r, w_bl8_r);

    // per-lane storage; with termination off the byte mask gates each lane on its own
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        logic [7:0] lane_mem [DEPTH];
        always_ff @(posedge link_clk)
        begin
            // mask becomes the termination strobe when enabled
            if (w_left_r != 4'h0 && (s_term || !write_byte_mask[g]))
                lane_mem[w_idx] <= wr_data[8*g +: 8];
        end
        assign r_word[8*g +: 8] = lane_mem[r_idx];
    end

    // read burst engine; a new burst start replaces any tail
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            r_left_r <= 4'h0;
            r_beat_r <= 4'h0;
            r_bl8_r <= 1'b0;
            r_base_r <= '0;
        end
        else if (r_ent[PW-1] && !r_ent[PW-2])
        begin
            r_left_r <= r_ent[PW-3] ? DDRB_BEATS_BL8 : DDRB_BEATS_BC4;
            r_beat_r <= 4'h0;
            r_bl8_r <= r_ent[PW-3];
            r_base_r <= r_ent[AW-1:0];
        end
        else if (r_left_r != 4'h0)
        begin
            r_left_r <= r_left_r - 4'h1;
            r_beat_r <= r_beat_r + 4'h1;
        end
    end

    // read data launched one beat per link clock from flops
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            rd_data_r <= '0;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_valid_r <= (r_left_r != 4'h0);
            rd_data_r <= (r_left_r != 4'h0) ? r_word : '0;
        end
    end

    // write burst engine; beats are sampled while w_left_r is non-zero
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            w_left_r <= 4'h0;
            w_beat_r <= 4'h0;
            w_bl8_r <= 1'b0;
            w_base_r <= '0;
        end
        else if (w_ent[PW-1] && w_ent[PW-2])
        begin
            w_left_r <= w_ent[PW-3] ? DDRB_BEATS_BL8 : DDRB_BEATS_BC4;
            w_beat_r <= 4'h0;
            w_bl8_r <= w_ent[PW-3];
            w_base_r <= w_ent[AW-1:0];
        end
        else if (w_left_r != 4'h0)
        begin
            w_left_r <= w_left_r - 4'h1;
            w_beat_r <= w_beat_r + 4'h1;
        end
    end

    // strobe faults are only counted; control state is never disturbed
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            w_fault_r <= 1'b0;
        else if (w_left_r == 4'h1)
            w_fault_r <= 1'b0;
        else if (w_left_r != 4'h0 && wr_strobe_fault)
            w_fault_r <= 1'b1;
    end

    // completion toggles for the core-side counters
    always_ff @(posedge link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
            ev_tgl_r <= 3'h0;
        else
        begin
            if (r_left_r == 4'h1)
                ev_tgl_r[0] <= !ev_tgl_r[0];
            if (w_left_r == 4'h1)
                ev_tgl_r[1] <= !ev_tgl_r[1];
            if (w_left_r == 4'h1 && (w_fault_r || wr_strobe_fault))
                ev_tgl_r[2] <= !ev_tgl_r[2];
        end
    end

    // outputs; strobe and beat flag are gated flop values
    assign wr_beat = (w_left_r != 4'h0);
    assign termination_strobe = s_term && (w_left_r != 4'h0);
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;

endmodule

`default_nettype wire

// ---- bench/ddrb_burst_asserts.sv ----
// assertion checker for the burst engine ports
`timescale 1ns/1ps
`default_nettype none
module ddrb_burst_asserts
    import ddrb_pkg::*;
(
    // core side
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // link side
    input wire logic link_clk,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_a12,
    input wire logic wr_beat,
    input wire logic termination_strobe,
    input wire logic rd_valid
);
    logic [1:0] blf_r;
    logic term_r;
    logic bl8_w, rd_cmd, wr_cmd, mapped;
    // burst field shadow; valid because config only moves while idle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            blf_r <= DDRB_BLF_RST;
            term_r <= DDRB_TERM_RST;
        end
        else if (psel && penable && pwrite && paddr == DDRB_CTRL_OFS)
        begin
            blf_r <= pwdata[1:0];
            term_r <= pwdata[DDRB_CTRL_TERM_BIT];
        end
    end
    // command decode as the device should see it
    assign bl8_w = blf_r == DDRB_BLF_FIXED8
        || (blf_r == DDRB_BLF_OTF && cmd_a12);
    assign rd_cmd = cmd_valid && !cmd_write;
    assign wr_cmd = cmd_valid && cmd_write;
    assign mapped = paddr == DDRB_CTRL_OFS || paddr == DDRB_LAT_OFS
        || paddr == DDRB_STAT_OFS;
    // a chopped burst may run on only if another command followed at tCCD
    sequence s_rd8; ##7 rd_valid [*8]; endsequence
    sequence s_wr8; ##5 wr_beat [*8]; endsequence
    sequence s_rd4; ##7 rd_valid [*4] ##1 (!rd_valid || $past(rd_cmd, 7));
    endsequence
    sequence s_wr4; ##5 wr_beat [*4] ##1 (!wr_beat || $past(wr_cmd, 5));
    endsequence
    a_rd_eight_len: assert property (@(posedge link_clk) disable iff (!nrst)
        rd_cmd && bl8_w |-> s_rd8) else $error("read burst too short");
    a_rd_chop_len: assert property (@(posedge link_clk) disable iff (!nrst)
        rd_cmd && !bl8_w |-> s_rd4) else $error("read chop length wrong");
    a_wr_eight_len: assert property (@(posedge link_clk) disable iff (!nrst)
        wr_cmd && bl8_w |-> s_wr8) else $error("write burst too short");
    a_wr_chop_len: assert property (@(posedge link_clk) disable iff (!nrst)
        wr_cmd && !bl8_w |-> s_wr4) else $error("write chop length wrong");
    a_rd_data_start: assert property (@(posedge link_clk) disable iff (!nrst)
        $rose(rd_valid) |-> $past(rd_cmd, 7)) else $error("read data early");
    a_wr_beat_start: assert property (@(posedge link_clk) disable iff (!nrst)
        $rose(wr_beat) |-> $past(wr_cmd, 5)) else $error("write beat early");
    a_term_lane: assert property (@(posedge link_clk) disable iff (!nrst)
        wr_cmd |-> ##5 (termination_strobe == term_r) [*4])
        else $error("termination strobe wrong");
    a_term_only_wr: assert property (@(posedge link_clk) disable iff (!nrst)
        termination_strobe |-> wr_beat) else $error("strobe outside write");
    a_apb_map: assert property (@(posedge clk) disable iff (!nrst)
        psel && penable |-> pready && pslverr == !mapped)
        else $error("apb answer wrong");
endmodule
bind ddrb_burst ddrb_burst_asserts u_chk (.clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .link_clk, .cmd_valid,
    .cmd_write, .cmd_a12, .wr_beat, .termination_strobe, .rd_valid);
`default_nettype wire

// ---- bench/ddrb_ctl_model.sv ----
// memory controller model: column commands, write beats, read capture
`timescale 1ns/1ps
`default_nettype none
module ddrb_ctl_model
(
    // link clock and device outputs
    input wire logic link_clk,
    input wire logic wr_beat,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    // commands and write data
    output logic cmd_valid,
    output logic cmd_write,
    output logic [2:0] cmd_bank,
    output logic [5:0] cmd_col,
    output logic cmd_a12,
    output logic [7:0] wr_data,
    output logic [0:0] write_byte_mask,
    output logic wr_strobe_fault
);
    logic [7:0] wbase = 8'h00;
    logic [3:0] bcnt = 4'h0;
    logic wmsk = 1'b0;
    logic wflt = 1'b0;
    logic [7:0] rq[$];
    // idle data and mask lines carry the inverse so stale data never looks valid; the fault line idles low
    assign wr_data = wr_beat ? wbase + {4'h0, bcnt} : ~(wbase + {4'h0, bcnt});
    assign write_byte_mask = wr_beat ? wmsk : ~wmsk;
    assign wr_strobe_fault = wr_beat && wflt;
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_bank = 3'h0;
        cmd_col = 6'h00;
        cmd_a12 = 1'b0;
    end
    // beat index and read capture
    always @(posedge link_clk)
    begin
        bcnt <= wr_beat ? bcnt + 4'h1 : 4'h0;
        if (rd_valid)
            rq.push_back(rd_data);
    end
    // only column commands, so row spacing never arises
    task automatic issue(input logic wr, input logic a12,
        input logic [5:0] col, input logic [7:0] base, input logic msk,
        input logic flt);
        @(posedge link_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_a12 <= a12;
        cmd_col <= col;
        wbase <= base;
        wmsk <= msk;
        wflt <= flt;
        @(posedge link_clk);
        cmd_valid <= 1'b0;
        cmd_write <= ~wr;
        cmd_a12 <= ~a12;
        cmd_col <= ~col;
        repeat (2) @(posedge link_clk);
    endtask
endmodule
`default_nettype wire

// ---- bench/ddrb_burst_test.sv ----
// self-checking bench for the burst engine
`timescale 1ns/1ps
`default_nettype none
module ddrb_burst_test
    import ddrb_pkg::*;
;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q, s0;
    logic pready, pslverr, e, cmd_valid, cmd_write, cmd_a12, wr_beat;
    logic wr_strobe_fault, termination_strobe, rd_valid;
    logic [2:0] cmd_bank;
    logic [5:0] cmd_col;
    logic [7:0] wr_data, rd_data;
    logic [0:0] write_byte_mask;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    // core 50 ns, link 64 ns with an unrelated phase
    initial forever #25 clk = ~clk;
    initial #7 forever #32 link_clk = ~link_clk;
    ddrb_burst DUT (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .link_clk, .cmd_valid, .cmd_write,
        .cmd_bank, .cmd_col, .cmd_a12, .wr_data, .write_byte_mask,
        .wr_strobe_fault, .wr_beat, .termination_strobe, .rd_data, .rd_valid);
    ddrb_ctl_model CTL (.link_clk, .wr_beat, .rd_valid, .rd_data, .cmd_valid,
        .cmd_write, .cmd_bank, .cmd_col, .cmd_a12, .wr_data,
        .write_byte_mask, .wr_strobe_fault);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one transfer; held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // config is level synced, so give it link edges before traffic
    task automatic cfg(input logic [2:0] v);
        apb(1'b1, DDRB_CTRL_OFS, {29'h0, v});
        repeat (6) @(posedge link_clk);
    endtask
    // the wait covers the last beat plus recovery before the next read
    task automatic wr(input logic a12, input logic [5:0] col,
        input logic [7:0] base, input logic msk, input logic flt);
        CTL.issue(1'b1, a12, col, base, msk, flt);
        repeat (14) @(posedge link_clk);
    endtask
    task automatic rd_chk(input logic a12, input logic [5:0] col, input int n,
        input logic [7:0] base);
        CTL.rq.delete();
        CTL.issue(1'b0, a12, col, 8'h00, 1'b0, 1'b0);
        repeat (16) @(posedge link_clk);
        chk(CTL.rq.size(), n);
        for (int k = 0; k < n; k++)
            chk(CTL.rq[k], base + k);
    endtask
    task automatic t_regs();
        apb(1'b0, DDRB_CTRL_OFS, 32'h0);
        chk(q, {29'h0, DDRB_TERM_RST, DDRB_BLF_RST});
        chk({31'h0, e}, 32'h0);
        apb(1'b0, DDRB_LAT_OFS, 32'h0);
        chk(q, {11'h0, DDRB_CWL_RST, 3'h0, DDRB_CL_RST, 3'h0, DDRB_AL_RST});
        apb(1'b1, DDRB_STAT_OFS, 32'hff);
        apb(1'b0, DDRB_STAT_OFS, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, 8'h0c, 32'h5);
        chk({31'h0, e}, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        chk({q[30:0], e}, 32'h1);
    endtask
    task automatic t_burst();
        wr(1'b1, 6'h08, 8'h20, 1'b0, 1'b0);
        rd_chk(1'b1, 6'h08, 8, 8'h20);
        rd_chk(1'b0, 6'h08, 4, 8'h20);
        CTL.rq.delete();
        CTL.issue(1'b0, 1'b0, 6'h08, 8'h00, 1'b0, 1'b0);
        CTL.issue(1'b0, 1'b0, 6'h08, 8'h00, 1'b0, 1'b0);
        repeat (16) @(posedge link_clk);
        chk(CTL.rq.size(), 8);
        chk(CTL.rq[4], 8'h20);
        wr(1'b0, 6'h10, 8'h40, 1'b0, 1'b0);
        wr(1'b0, 6'h10, 8'h80, 1'b1, 1'b0);
        rd_chk(1'b0, 6'h10, 4, 8'h40);
    endtask
    task automatic t_modes();
        cfg({1'b0, DDRB_BLF_FIXED8});
        rd_chk(1'b0, 6'h08, 8, 8'h20);
        cfg({1'b0, DDRB_BLF_CHOP4});
        rd_chk(1'b1, 6'h08, 4, 8'h20);
        cfg(3'h3);
        rd_chk(1'b1, 6'h08, 4, 8'h20);
        cfg({1'b1, DDRB_BLF_OTF});
        wr(1'b0, 6'h18, 8'h60, 1'b1, 1'b0);
        rd_chk(1'b0, 6'h18, 4, 8'h60);
        cfg({1'b0, DDRB_BLF_OTF});
    endtask
    task automatic t_fault();
        apb(1'b0, DDRB_STAT_OFS, 32'h0);
        s0 = q;
        wr(1'b0, 6'h20, 8'h70, 1'b0, 1'b1);
        apb(1'b0, DDRB_STAT_OFS, 32'h0);
        chk(q, s0 + 32'h0001_0100);
        wr(1'b0, 6'h24, 8'h90, 1'b0, 1'b0);
        rd_chk(1'b0, 6'h24, 4, 8'h90);
        rd_chk(1'b1, 6'h08, 8, 8'h20);
    endtask
    // controller reinitialises after the fault; counters clear, array kept
    task automatic t_reinit();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge link_clk);
        apb(1'b0, DDRB_STAT_OFS, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, DDRB_CTRL_OFS, 32'h0);
        chk(q, {29'h0, DDRB_TERM_RST, DDRB_BLF_RST});
        rd_chk(1'b1, 6'h08, 8, 8'h20);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge link_clk);
        t_regs();
        t_burst();
        t_modes();
        t_fault();
        t_reinit();
        tally_and_finish();
    end
endmodule
`default_nettype wire
